// [pkg/port_option_pkg.sv]
// constants, field layout and decode helpers of the port/option bank
// assumes a 32-bit AHB-Lite bus, one aligned word per register
package port_option_pkg;

    // =========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SERIAL_B_BUFFER = 8'h8F;
    localparam logic [7:0] IDX_PORT1_DATA_LATCH = 8'h90;
    localparam logic [7:0] IDX_PORT0_PUSH_PULL = 8'h91;
    localparam logic [7:0] IDX_PORT0_LCD_BIAS = 8'h92;
    localparam logic [7:0] IDX_PORT2_PIN_MODE = 8'h93;
    localparam logic [7:0] IDX_MISC_OPTION = 8'h94;

    // =========================================================
    // reset values
    localparam logic [7:0] RST_SERIAL_B_BUFFER = 8'h00;
    localparam logic [7:0] RST_PORT1_DATA_LATCH = 8'hFF;
    localparam logic [7:0] RST_PORT0_PUSH_PULL = 8'h00;
    localparam logic [7:0] RST_PORT0_LCD_BIAS = 8'h00;
    localparam logic [7:0] RST_PORT2_PIN_MODE = 8'h05;
    localparam logic [7:0] RST_MISC_OPTION = 8'h00;

    // =========================================================
    // field positions and writable bits
    localparam int UPPER_MODE_LSB = 2;
    localparam int LOWER_MODE_LSB = 0;
    localparam int SINGLE_WIRE_BIT = 7;
    localparam int AUTOTUNE_BIT = 6;
    localparam int WDT_SEL_LSB = 4;
    localparam int SLOW_SEL_LSB = 0;
    localparam logic [7:0] MASK_PORT2_PIN_MODE = 8'hCF;
    localparam logic [7:0] MASK_MISC_OPTION = 8'h33;

    // =========================================================
    // watchdog overflow period in ms, per select code
    localparam logic [8:0] WDT_MS_CODE0 = 9'h1E0;
    localparam logic [8:0] WDT_MS_CODE1 = 9'h0F0;
    localparam logic [8:0] WDT_MS_CODE2 = 9'h078;
    localparam logic [8:0] WDT_MS_CODE3 = 9'h03C;

    // slow timer interrupt period in slow clock cycles, per code
    localparam logic [15:0] SLOW_CYC_CODE0 = 16'h8000;
    localparam logic [15:0] SLOW_CYC_CODE1 = 16'h2000;
    localparam logic [15:0] SLOW_CYC_CODE2 = 16'h0800;
    localparam logic [15:0] SLOW_CYC_CODE3 = 16'h0080;

    // bus address bits that must be zero for a mapped word
    localparam logic [31:0] ADDR_ZERO_MASK = 32'hFFFFFC03;

    typedef logic [7:0] reg_index_type;

    // word address to register index, valid flag in bit 8
    function automatic logic [8:0] decodeAddr(input logic [31:0] addr);
        logic [7:0] idx;
        logic hit;
        idx = addr[9:2];
        hit = ((addr & ADDR_ZERO_MASK) == 32'h00000000) &&
              (idx >= IDX_SERIAL_B_BUFFER) && (idx <= IDX_MISC_OPTION);
        return {hit, idx};
    endfunction

endpackage

// [pkg/reg_access_if.sv]
// register access strobes between the bus port and the register bank
// assumes one clock; strobes are single-cycle
interface reg_access_if;
    import port_option_pkg::*;
    logic wrEn;
    reg_index_type wrIdx;
    logic [7:0] wrData;
    logic rdEn;
    reg_index_type rdIdx;

    modport port (output wrEn, wrIdx, wrData, rdEn, rdIdx);
    modport bank (input wrEn, wrIdx, wrData, rdEn, rdIdx);
endinterface

// [src/ahb_slave_port.sv]
// AHB-Lite slave front end: turns transfers into read/write strobes
// assumes single word transfers; no wait states are inserted
module ahb_slave_port
    import port_option_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bus address and data phase
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    // strobes towards the bank
    reg_access_if.port acc
);
    logic [8:0] decoded;
    logic addrPhase;
    logic pendWrite;
    reg_index_type pendIdx;

    assign decoded = decodeAddr(haddr);
    assign addrPhase = hsel && htrans[1] && hready;

    // =========================================================
    // address phase capture for writes
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pendWrite <= 1'b0;
            pendIdx <= 8'h00;
        end else begin
            pendWrite <= addrPhase && hwrite && decoded[8];
            pendIdx <= decoded[7:0];
        end
    end

    // =========================================================
    // strobes: write in data phase, read in address phase
    assign acc.wrEn = pendWrite;
    assign acc.wrIdx = pendIdx;
    assign acc.wrData = hwdata[7:0];
    assign acc.rdEn = addrPhase && !hwrite && decoded[8];
    assign acc.rdIdx = decoded[7:0];
endmodule

// [src/port_option_sfr_bank.sv]
// port and option register bank with an AHB-Lite register port
// assumes one clock domain; pin drivers and timers sit outside
//
// Overview of operation
// - each push-pull enable bit drives its Port0 pin push-pull; resets zero
// - each LCD bias enable bit enables half-bias on its Port0 pin; resets zero
// - Port2 mode fields pick mode 0/1/2, reset 01; 11 must not be written
// - single-wire bit shares one pin for serial transmit and receive; reset 0
// - watchdog select codes 01/10/11 give 240, 120, 60 ms
// - watchdog select code 00, the reset value, gives 480 ms
// - slow timer select sets interrupt period: 00 is 32768, 11 is 128 cycles
module port_option_sfr_bank
    import port_option_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // port controls
    output logic [7:0] port1DataLatch,
    output logic [7:0] port0PushPullEnable,
    output logic [7:0] port0LcdBiasEnable,
    output logic [1:0] port2UpperPinMode,
    output logic [1:0] port2LowerPinMode,
    output logic singleWireSerialMode,
    output logic touchClockAutotune,
    output logic [7:0] serialBBuffer,
    // option controls
    output logic [1:0] watchdogPeriodSelect,
    output logic [8:0] watchdogPeriodMs,
    output logic [1:0] slowTimerRateSelect,
    output logic [15:0] slowTimerPeriod
);
    reg_access_if acc();

    logic [7:0] port2PinMode;
    logic [7:0] miscOption;
    logic [7:0] next_port2PinMode;
    logic [7:0] next_miscOption;
    logic [7:0] readValue;

    // =========================================================
    // bus front end
    ahb_slave_port u_port (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .acc(acc)
    );

    // =========================================================
    // plain data registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port1DataLatch <= RST_PORT1_DATA_LATCH;
            serialBBuffer <= RST_SERIAL_B_BUFFER;
        end else if (acc.wrEn) begin
            if (acc.wrIdx == IDX_PORT1_DATA_LATCH) begin
                port1DataLatch <= acc.wrData;
            end
            if (acc.wrIdx == IDX_SERIAL_B_BUFFER) begin
                serialBBuffer <= acc.wrData;
            end
        end
    end

    // =========================================================
    // Port0 drive enables
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port0PushPullEnable <= RST_PORT0_PUSH_PULL;
            port0LcdBiasEnable <= RST_PORT0_LCD_BIAS;
        end else if (acc.wrEn) begin
            if (acc.wrIdx == IDX_PORT0_PUSH_PULL) begin
                port0PushPullEnable <= acc.wrData;
            end
            if (acc.wrIdx == IDX_PORT0_LCD_BIAS) begin
                port0LcdBiasEnable <= acc.wrData;
            end
        end
    end

    // =========================================================
    // Port2 mode and option registers, unused bits held at zero
    always_comb begin
        next_port2PinMode = port2PinMode;
        next_miscOption = miscOption;
        if (acc.wrEn && acc.wrIdx == IDX_PORT2_PIN_MODE) begin
            next_port2PinMode = acc.wrData & MASK_PORT2_PIN_MODE;
        end
        if (acc.wrEn && acc.wrIdx == IDX_MISC_OPTION) begin
            next_miscOption = acc.wrData & MASK_MISC_OPTION;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port2PinMode <= RST_PORT2_PIN_MODE;
            miscOption <= RST_MISC_OPTION;
        end else begin
            port2PinMode <= next_port2PinMode;
            miscOption <= next_miscOption;
        end
    end

    // =========================================================
    // decoded control outputs, registered from the next values
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port2UpperPinMode <= RST_PORT2_PIN_MODE[3:2];
            port2LowerPinMode <= RST_PORT2_PIN_MODE[1:0];
            singleWireSerialMode <= RST_PORT2_PIN_MODE[7];
            touchClockAutotune <= RST_PORT2_PIN_MODE[6];
            watchdogPeriodSelect <= RST_MISC_OPTION[5:4];
            slowTimerRateSelect <= RST_MISC_OPTION[1:0];
        end else begin
            port2UpperPinMode <= next_port2PinMode[UPPER_MODE_LSB +: 2];
            port2LowerPinMode <= next_port2PinMode[LOWER_MODE_LSB +: 2];
            singleWireSerialMode <= next_port2PinMode[SINGLE_WIRE_BIT];
            touchClockAutotune <= next_port2PinMode[AUTOTUNE_BIT];
            watchdogPeriodSelect <= next_miscOption[WDT_SEL_LSB +: 2];
            slowTimerRateSelect <= next_miscOption[SLOW_SEL_LSB +: 2];
        end
    end

    // =========================================================
    // watchdog and slow timer periods
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            watchdogPeriodMs <= WDT_MS_CODE0;
        end else begin
            case (next_miscOption[WDT_SEL_LSB +: 2])
                2'h0: watchdogPeriodMs <= WDT_MS_CODE0;
                2'h1: watchdogPeriodMs <= WDT_MS_CODE1;
                2'h2: watchdogPeriodMs <= WDT_MS_CODE2;
                default: watchdogPeriodMs <= WDT_MS_CODE3;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slowTimerPeriod <= SLOW_CYC_CODE0;
        end else begin
            case (next_miscOption[SLOW_SEL_LSB +: 2])
                2'h0: slowTimerPeriod <= SLOW_CYC_CODE0;
                2'h1: slowTimerPeriod <= SLOW_CYC_CODE1;
                2'h2: slowTimerPeriod <= SLOW_CYC_CODE2;
                default: slowTimerPeriod <= SLOW_CYC_CODE3;
            endcase
        end
    end

    // =========================================================
    // read path; a write in its data phase is forwarded
    always_comb begin
        case (acc.rdIdx)
            IDX_SERIAL_B_BUFFER: readValue = serialBBuffer;
            IDX_PORT1_DATA_LATCH: readValue = port1DataLatch;
            IDX_PORT0_PUSH_PULL: readValue = port0PushPullEnable;
            IDX_PORT0_LCD_BIAS: readValue = port0LcdBiasEnable;
            IDX_PORT2_PIN_MODE: readValue = port2PinMode;
            IDX_MISC_OPTION: readValue = miscOption;
            default: readValue = 8'h00;
        endcase
        if (acc.wrEn && acc.wrIdx == acc.rdIdx) begin
            if (acc.rdIdx == IDX_PORT2_PIN_MODE) begin
                readValue = next_port2PinMode;
            end else if (acc.rdIdx == IDX_MISC_OPTION) begin
                readValue = next_miscOption;
            end else begin
                readValue = acc.wrData;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (acc.rdEn) begin
                hrdata <= {24'h000000, readValue};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_push_pull_write: assert property (
        acc.wrEn && acc.wrIdx == IDX_PORT0_PUSH_PULL
        |=> port0PushPullEnable == $past(acc.wrData))
        else $error("push-pull enable not written");
    chk_lcd_bias_hold: assert property (
        !(acc.wrEn && acc.wrIdx == IDX_PORT0_LCD_BIAS)
        |=> $stable(port0LcdBiasEnable))
        else $error("lcd bias enable changed without write");
    chk_mode_field_map: assert property (
        acc.wrEn && acc.wrIdx == IDX_PORT2_PIN_MODE
        |=> port2UpperPinMode == $past(acc.wrData[3:2]) &&
        port2LowerPinMode == $past(acc.wrData[1:0]))
        else $error("mode field outputs differ from write");
    chk_single_wire: assert property (
        acc.wrEn && acc.wrIdx == IDX_PORT2_PIN_MODE
        |=> singleWireSerialMode == $past(acc.wrData[7]))
        else $error("single-wire mode not taken from write");
    chk_wdt_short: assert property (
        watchdogPeriodSelect == 2'h3 |-> watchdogPeriodMs == 9'h03C)
        else $error("watchdog code 11 not 60 ms");
    chk_wdt_mid: assert property (
        watchdogPeriodSelect == 2'h1 |-> watchdogPeriodMs == 9'h0F0)
        else $error("watchdog code 01 not 240 ms");
    chk_wdt_longest: assert property (
        watchdogPeriodSelect == 2'h0 |-> watchdogPeriodMs == 9'h1E0)
        else $error("watchdog code 00 not 480 ms");
    chk_slow_rate_ends: assert property (
        (slowTimerRateSelect == 2'h0 |-> slowTimerPeriod == 16'h8000) and
        (slowTimerRateSelect == 2'h3 |-> slowTimerPeriod == 16'h0080))
        else $error("slow timer period wrong at end codes");
    chk_read_answer: assert property (
        acc.rdEn |=> hrdata[31:8] == 24'h000000 && hreadyout)
        else $error("read answer malformed");

    cov_push_pull_write: cover property (
        acc.wrEn && acc.wrIdx == IDX_PORT0_PUSH_PULL);
    cov_single_wire_on: cover property ($rose(singleWireSerialMode));
    cov_wdt_short: cover property (watchdogPeriodSelect == 2'h3);
    cov_read_after_write: cover property (
        acc.wrEn && acc.rdEn && acc.wrIdx == acc.rdIdx);
endmodule

// [dv/tb.sv]
// self-checking bench of the port/option register bank
// assumes the bank's AHB-Lite port answers with no wait states
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import port_option_pkg::*;

    // =========================================================
    // clock, reset and bus signals
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout, hresp;
    logic [7:0] port1DataLatch, port0PushPullEnable, port0LcdBiasEnable;
    logic [1:0] port2UpperPinMode, port2LowerPinMode;
    logic singleWireSerialMode, touchClockAutotune;
    logic [7:0] serialBBuffer;
    logic [1:0] watchdogPeriodSelect, slowTimerRateSelect;
    logic [8:0] watchdogPeriodMs;
    logic [15:0] slowTimerPeriod;
    int numErrors = 0;
    int nCompared = 0;
    int cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    port_option_sfr_bank u_port_option_sfr_bank (
        .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .port1DataLatch(port1DataLatch),
        .port0PushPullEnable(port0PushPullEnable),
        .port0LcdBiasEnable(port0LcdBiasEnable),
        .port2UpperPinMode(port2UpperPinMode),
        .port2LowerPinMode(port2LowerPinMode),
        .singleWireSerialMode(singleWireSerialMode),
        .touchClockAutotune(touchClockAutotune),
        .serialBBuffer(serialBBuffer),
        .watchdogPeriodSelect(watchdogPeriodSelect),
        .watchdogPeriodMs(watchdogPeriodMs),
        .slowTimerRateSelect(slowTimerRateSelect),
        .slowTimerPeriod(slowTimerPeriod));

    // =========================================================
    // checking and closing
    task automatic expect32(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
        nCompared++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            $display("BAD %0t run did not finish", $time);
            summarize();
        end
    end

    // =========================================================
    // bus transfers
    task automatic busXfer(input logic wr, input logic [31:0] addr,
                           input logic [31:0] wdata, output logic [31:0] rdata);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdata = hrdata;
        expect32({31'h00000000, hresp}, 32'h00000000, "response");
    endtask

    function automatic logic [31:0] byteAddr(input logic [7:0] idx);
        return {22'h000000, idx, 2'b00};
    endfunction

    task automatic regWrite(input logic [7:0] idx, input logic [7:0] val);
        logic [31:0] rd;
        busXfer(1'b1, byteAddr(idx), {24'hA5C35A, val}, rd);
        #1;
    endtask

    task automatic regRead(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        busXfer(1'b0, byteAddr(idx), 32'h00000000, rd);
        expect32(rd, {24'h000000, exp}, "read data");
    endtask

    // =========================================================
    // scenarios
    task automatic testResetValues();
        regRead(IDX_PORT1_DATA_LATCH, 8'hFF);
        regRead(IDX_PORT0_PUSH_PULL, 8'h00);
        regRead(IDX_PORT0_LCD_BIAS, 8'h00);
        regRead(IDX_PORT2_PIN_MODE, 8'h05);
        expect32({30'h0, port2UpperPinMode}, 32'h1, "upper mode");
        expect32({30'h0, port2LowerPinMode}, 32'h1, "lower mode");
        expect32({31'h0, singleWireSerialMode}, 32'h0, "one wire");
        regRead(IDX_MISC_OPTION, 8'h00);
        expect32({23'h0, watchdogPeriodMs}, 32'h1E0, "wdt ms");
        expect32({16'h0, slowTimerPeriod}, 32'h8000, "slow period");
        $display("test reset values done");
    endtask

    task automatic testPortEnables();
        logic [7:0] pats [3] = '{8'h01, 8'h80, 8'h5A};
        foreach (pats[i]) begin
            regWrite(IDX_PORT0_PUSH_PULL, pats[i]);
            expect32({24'h0, port0PushPullEnable}, {24'h0, pats[i]}, "pp");
            regWrite(IDX_PORT0_LCD_BIAS, ~pats[i]);
            expect32({24'h0, port0LcdBiasEnable}, {24'h0, ~pats[i]}, "lcd");
            expect32({24'h0, port0PushPullEnable}, {24'h0, pats[i]}, "pp");
            regRead(IDX_PORT0_PUSH_PULL, pats[i]);
            regRead(IDX_PORT0_LCD_BIAS, ~pats[i]);
        end
        regWrite(IDX_PORT1_DATA_LATCH, 8'h3C);
        expect32({24'h0, port1DataLatch}, 32'h3C, "port1");
        regWrite(IDX_SERIAL_B_BUFFER, 8'hC3);
        regRead(IDX_SERIAL_B_BUFFER, 8'hC3);
        $display("test port enables done");
    endtask

    task automatic testPinModes();
        logic [7:0] v;
        for (int c = 0; c < 3; c++) begin
            v = {1'b0, 1'b0, 2'b11, c[1:0], 2'(2 - c)};
            regWrite(IDX_PORT2_PIN_MODE, v);
            expect32({30'h0, port2UpperPinMode}, c, "upper mode");
            expect32({30'h0, port2LowerPinMode}, 2 - c, "lower mode");
            expect32({31'h0, singleWireSerialMode}, 32'h0, "one wire");
            regRead(IDX_PORT2_PIN_MODE, v & 8'hCF);
        end
        regWrite(IDX_PORT2_PIN_MODE, 8'hB5);
        expect32({31'h0, singleWireSerialMode}, 32'h1, "one wire");
        regRead(IDX_PORT2_PIN_MODE, 8'h85);
        $display("test pin modes done");
    endtask

    task automatic testOptionCodes();
        int wdtMs [4] = '{480, 240, 120, 60};
        int slowCyc [4] = '{32768, 8192, 2048, 128};
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            v = {2'b00, c[1:0], 2'b00, 2'(3 - c)};
            regWrite(IDX_MISC_OPTION, v | 8'hCC);
            expect32({30'h0, watchdogPeriodSelect}, c, "wdt sel");
            expect32({23'h0, watchdogPeriodMs}, wdtMs[c], "wdt ms");
            expect32({30'h0, slowTimerRateSelect}, 3 - c, "slow sel");
            expect32({16'h0, slowTimerPeriod}, slowCyc[3 - c], "slow");
            regRead(IDX_MISC_OPTION, v);
        end
        $display("test option codes done");
    endtask

    task automatic testUnmapped();
        logic [31:0] rd;
        busXfer(1'b1, 32'h00000254, 32'h000000FF, rd);
        busXfer(1'b0, 32'h00000254, 32'h00000000, rd);
        expect32(rd, 32'h00000000, "unmapped above");
        busXfer(1'b0, 32'h00000238, 32'h00000000, rd);
        expect32(rd, 32'h00000000, "unmapped below");
        regRead(IDX_MISC_OPTION, 8'h30);
        $display("test unmapped done");
    endtask

    task automatic testMidReset();
        regWrite(IDX_PORT2_PIN_MODE, 8'hC6);
        expect32({31'h0, touchClockAutotune}, 32'h1, "autotune");
        expect32({30'h0, port2LowerPinMode}, 32'h2, "lower mode");
        regWrite(IDX_PORT0_PUSH_PULL, 8'hFF);
        expect32({24'h0, serialBBuffer}, 32'hC3, "serial buffer");
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        expect32({24'h0, port0PushPullEnable}, 32'h0, "pp reset");
        expect32({30'h0, port2LowerPinMode}, 32'h1, "lower reset");
        expect32({31'h0, singleWireSerialMode}, 32'h0, "one wire");
        expect32({31'h0, touchClockAutotune}, 32'h0, "autotune reset");
        expect32({24'h0, serialBBuffer}, 32'h0, "serial reset");
        regRead(IDX_PORT2_PIN_MODE, 8'h05);
        regRead(IDX_MISC_OPTION, 8'h00);
        $display("test mid reset done");
    endtask

    // =========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        testResetValues();
        testPortEnables();
        testPinModes();
        testOptionCodes();
        testUnmapped();
        testMidReset();
        summarize();
    end
endmodule
